// ===== verilog/txsil_pkg.sv
// package: register map, field positions and event carrier for tx status logic
package txsil_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] TXSIL_OFF_LS1   = 12'h190;
   localparam logic [11:0] TXSIL_OFF_LS2   = 12'h191;
   localparam logic [11:0] TXSIL_OFF_LS3   = 12'h192;
   localparam logic [11:0] TXSIL_OFF_SUM   = 12'h19F;
   localparam logic [11:0] TXSIL_OFF_IM1   = 12'h1A0;
   localparam logic [11:0] TXSIL_OFF_IM2   = 12'h1A1;
   localparam logic [11:0] TXSIL_OFF_IM3   = 12'h1A2;
   localparam logic [11:0] TXSIL_OFF_CTRL  = 12'h1A8;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TXSIL_B_FULL    = 7;
   localparam int TXSIL_B_EMPTY   = 6;
   localparam int TXSIL_B_SLIP    = 5;
   localparam int TXSIL_B_SLC     = 4;
   localparam int TXSIL_B_PDV_AF  = 3;
   localparam int TXSIL_B_MF      = 2;
   localparam int TXSIL_B_CLKOK   = 1;
   localparam int TXSIL_B_CLKLOST = 0;
   localparam int TXSIL_B_LINK    = 4;
   localparam int TXSIL_B_UDR     = 3;
   localparam int TXSIL_B_MEND    = 2;
   localparam int TXSIL_B_LWM     = 1;
   localparam int TXSIL_B_NF      = 0;
   localparam int TXSIL_B_SEARCH  = 1;
   localparam int TXSIL_B_SDET    = 0;
   localparam int TXSIL_B_E1      = 0;  // control: 1 = E1, 0 = T1
   localparam int TXSIL_B_SLC_EN  = 1;  // control: slc multiframe event enable

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] TXSIL_RST_BYTE   = 8'h00;
   localparam logic [7:0] TXSIL_LS2_MASK   = 8'h1F;
   localparam logic [7:0] TXSIL_LS3_MASK   = 8'h01;
   localparam int         TXSIL_LOST_EDGES = 3;   // missing line-clock periods
   localparam int         TXSIL_LINE_DIV   = 8;   // device clocks per line period

   // event pulses from the transmit datapath, one cycle each
   typedef struct packed {
      logic elastic_full_event;
      logic elastic_empty_event;
      logic elastic_slip_event;
      logic slc_multiframe_event;
      logic pulse_density_violation;
      logic align_frame_event;
      logic multiframe_event;
      logic link_shifter_empty;
      logic fifo_underrun_event;
      logic message_end_event;
   } txsil_evt_t;

   // level conditions from the transmit datapath
   typedef struct packed {
      logic below_watermark_cond;
      logic fifo_has_space_cond;
      logic sync_searching;
   } txsil_cond_t;

endpackage

// ===== verilog/txsil_top.sv
// tx latched status, masks, source summary and active-low interrupt for one port
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module txsil_top
   import txsil_pkg::*;
#(
   parameter int LOST_EDGES = TXSIL_LOST_EDGES,
   parameter int LINE_DIV   = TXSIL_LINE_DIV
)(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata,
   input  wire txsil_evt_t  evt,
   input  wire txsil_cond_t cond,
   input  wire logic        tx_line_clock,
   output var  logic        tx_clock_lost,
   output var  logic        irq_n
);

   localparam int WD_MAX = LOST_EDGES * LINE_DIV;
   localparam int WD_W   = $clog2(WD_MAX + 1);

   typedef struct packed {
      logic [7:0]      ls1_reg;
      logic [7:0]      ls2_reg;
      logic            ls3_reg;
      logic [7:0]      im1_reg;
      logic [7:0]      im2_reg;
      logic            im3_reg;
      logic [1:0]      ctrl_reg;
      logic [7:0]      rdata_reg;
      logic            irq_n_reg;
      logic            lost_reg;
      logic [WD_W-1:0] wd_cnt_reg;
      logic            lclk_prev_reg;
      logic            lwm_prev_reg;
      logic            nf_prev_reg;
      logic            search_prev_reg;
   } txsil_state_t;

   txsil_state_t st_reg;
   txsil_state_t st_next;

   // write-one-to-clear merge: a set arriving with the clear wins
   function automatic logic [7:0] w1c(input logic [7:0] cur,
                                      input logic [7:0] set,
                                      input logic [7:0] clr);
      w1c = (cur & ~clr) | set;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   logic [7:0] set1;
   logic [7:0] set2;
   logic       set3;
   logic [7:0] clr1;
   logic [7:0] clr2;
   logic       clr3;
   logic       edge_seen;
   logic       lost_now;
   logic [2:0] pend;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      st_next   = st_reg;
      edge_seen = (tx_line_clock != st_reg.lclk_prev_reg);
      lost_now  = 1'b0;
      st_next.lclk_prev_reg = tx_line_clock;
      // line clock watchdog: counts device clocks since the last transition
      if (edge_seen) begin
         st_next.wd_cnt_reg = '0;
      end else if (st_reg.wd_cnt_reg != WD_W'(WD_MAX)) begin
         st_next.wd_cnt_reg = st_reg.wd_cnt_reg + WD_W'(1);
      end
      if (!edge_seen && (st_reg.wd_cnt_reg == WD_W'(WD_MAX - 1))) begin
         lost_now = 1'b1;
      end
      // condition tracks the clock, independent of the status bit
      if (edge_seen) begin
         st_next.lost_reg = 1'b0;
      end else if (lost_now) begin
         st_next.lost_reg = 1'b1;
      end

      // event sets for status one
      set1 = '0;
      set1[TXSIL_B_FULL]  = evt.elastic_full_event;
      set1[TXSIL_B_EMPTY] = evt.elastic_empty_event;
      set1[TXSIL_B_SLIP]  = evt.elastic_slip_event | evt.elastic_full_event
                          | evt.elastic_empty_event;
      set1[TXSIL_B_SLC]   = !st_reg.ctrl_reg[TXSIL_B_E1] &&
                            st_reg.ctrl_reg[TXSIL_B_SLC_EN] &&
                            evt.slc_multiframe_event;
      set1[TXSIL_B_PDV_AF] = st_reg.ctrl_reg[TXSIL_B_E1] ? evt.align_frame_event
                                                         : evt.pulse_density_violation;
      set1[TXSIL_B_MF]      = evt.multiframe_event;
      set1[TXSIL_B_CLKOK]   = st_reg.lost_reg && edge_seen;
      set1[TXSIL_B_CLKLOST] = lost_now && !st_reg.lost_reg;

      // event sets for status two and three
      set2 = '0;
      set2[TXSIL_B_LINK] = !st_reg.ctrl_reg[TXSIL_B_E1] && evt.link_shifter_empty;
      set2[TXSIL_B_UDR]  = evt.fifo_underrun_event;
      set2[TXSIL_B_MEND] = evt.message_end_event;
      set2[TXSIL_B_LWM]  = cond.below_watermark_cond && !st_reg.lwm_prev_reg;
      set2[TXSIL_B_NF]   = cond.fifo_has_space_cond && !st_reg.nf_prev_reg;
      set3 = cond.sync_searching && !st_reg.search_prev_reg;
      st_next.lwm_prev_reg    = cond.below_watermark_cond;
      st_next.nf_prev_reg     = cond.fifo_has_space_cond;
      st_next.search_prev_reg = cond.sync_searching;

      // host clears by writing ones
      clr1 = (reg_wr && hit(reg_addr, TXSIL_OFF_LS1)) ? reg_wdata : 8'h00;
      clr2 = (reg_wr && hit(reg_addr, TXSIL_OFF_LS2)) ? reg_wdata : 8'h00;
      clr3 = reg_wr && hit(reg_addr, TXSIL_OFF_LS3) && reg_wdata[TXSIL_B_SDET];
      st_next.ls1_reg = w1c(st_reg.ls1_reg, set1, clr1);
      st_next.ls2_reg = w1c(st_reg.ls2_reg, set2, clr2) & TXSIL_LS2_MASK;
      st_next.ls3_reg = (st_reg.ls3_reg && !clr3) || set3;

      // mask and control writes
      if (reg_wr && hit(reg_addr, TXSIL_OFF_IM1)) begin
         st_next.im1_reg = reg_wdata;
      end
      if (reg_wr && hit(reg_addr, TXSIL_OFF_IM2)) begin
         st_next.im2_reg = reg_wdata & TXSIL_LS2_MASK;
      end
      if (reg_wr && hit(reg_addr, TXSIL_OFF_IM3)) begin
         st_next.im3_reg = reg_wdata[TXSIL_B_SDET];
      end
      if (reg_wr && hit(reg_addr, TXSIL_OFF_CTRL)) begin
         st_next.ctrl_reg = reg_wdata[1:0];
      end

      // pending summary from registered state and masks
      pend[0] = |(st_reg.ls1_reg & st_reg.im1_reg);
      pend[1] = |(st_reg.ls2_reg & st_reg.im2_reg);
      pend[2] = st_reg.ls3_reg & st_reg.im3_reg;
      st_next.irq_n_reg = ~|pend;

      // read data, valid in the cycle after the strobe
      st_next.rdata_reg = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            TXSIL_OFF_LS1:  st_next.rdata_reg = st_reg.ls1_reg;
            TXSIL_OFF_LS2:  st_next.rdata_reg = st_reg.ls2_reg;
            TXSIL_OFF_LS3:  st_next.rdata_reg = {6'h00, cond.sync_searching,
                                                  st_reg.ls3_reg};
            TXSIL_OFF_SUM:  st_next.rdata_reg = {5'h00, pend};
            TXSIL_OFF_IM1:  st_next.rdata_reg = st_reg.im1_reg;
            TXSIL_OFF_IM2:  st_next.rdata_reg = st_reg.im2_reg;
            TXSIL_OFF_IM3:  st_next.rdata_reg = {7'h00, st_reg.im3_reg};
            TXSIL_OFF_CTRL: st_next.rdata_reg = {6'h00, st_reg.ctrl_reg};
            default:        st_next.rdata_reg = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg           <= '0;
         st_reg.irq_n_reg <= 1'b1;
         st_reg.ls1_reg   <= TXSIL_RST_BYTE;
         st_reg.im1_reg   <= TXSIL_RST_BYTE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata     = st_reg.rdata_reg;
   assign irq_n         = st_reg.irq_n_reg;
   assign tx_clock_lost = st_reg.lost_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   AST_STICKY1: assert property (st_reg.ls1_reg[TXSIL_B_MF] && !clr1[TXSIL_B_MF]
      |=> st_reg.ls1_reg[TXSIL_B_MF]) else $error("status one bit dropped");
   AST_FULL: assert property (evt.elastic_full_event
      |=> st_reg.ls1_reg[TXSIL_B_FULL] && st_reg.ls1_reg[TXSIL_B_SLIP])
      else $error("elastic full not latched");
   AST_EMPTY: assert property (evt.elastic_empty_event |=> st_reg.ls1_reg[TXSIL_B_EMPTY])
      else $error("elastic empty not latched");
   AST_SLIP: assert property (evt.elastic_slip_event |=> st_reg.ls1_reg[TXSIL_B_SLIP])
      else $error("slip not latched");
   AST_E1AF: assert property (st_reg.ctrl_reg[TXSIL_B_E1] && evt.align_frame_event
      |=> st_reg.ls1_reg[TXSIL_B_PDV_AF]) else $error("align frame not latched");
   AST_LOST: assert property ($rose(st_reg.lost_reg)
      |-> st_reg.ls1_reg[TXSIL_B_CLKLOST]) else $error("clock loss not latched");
   AST_LIVE: assert property (st_reg.lost_reg && !edge_seen |=> st_reg.lost_reg)
      else $error("loss condition dropped early");
   AST_IRQ: assert property (st_reg.ls1_reg[TXSIL_B_CLKLOST] && st_reg.im1_reg[0]
      |=> !irq_n) else $error("irq not asserted");
   AST_NF: assert property (cond.fifo_has_space_cond && !st_reg.nf_prev_reg
      |=> st_reg.ls2_reg[TXSIL_B_NF]) else $error("not-full edge missed");
   AST_IDLE: assert property (st_reg.ls1_reg == 8'h00 && st_reg.ls2_reg == 8'h00
      && !st_reg.ls3_reg |=> irq_n) else $error("irq with nothing pending");

   // ------------------------------------------------------------
   // status one sources and mode gating
   // ------------------------------------------------------------
   // slc multiframe latches only in T1 with its enable set
   AST_SLC: assert property (!st_reg.ctrl_reg[TXSIL_B_E1] && st_reg.ctrl_reg[TXSIL_B_SLC_EN]
      && evt.slc_multiframe_event |=> st_reg.ls1_reg[TXSIL_B_SLC])
      else $error("slc multiframe not latched");
   // slc bit never rises while the event is gated off
   AST_SLC_OFF: assert property (st_reg.ctrl_reg != 2'h2 && !st_reg.ls1_reg[TXSIL_B_SLC]
      |=> !st_reg.ls1_reg[TXSIL_B_SLC])
      else $error("slc bit set while gated");
   // pulse density violation only counts in T1
   AST_PDV: assert property (!st_reg.ctrl_reg[TXSIL_B_E1] && evt.pulse_density_violation
      |=> st_reg.ls1_reg[TXSIL_B_PDV_AF])
      else $error("density violation not latched");
   // multiframe boundary latches in every mode
   AST_MF: assert property (evt.multiframe_event |=> st_reg.ls1_reg[TXSIL_B_MF])
      else $error("multiframe not latched");
   // first line clock edge after loss flags restore and ends the condition
   AST_CLKOK: assert property (st_reg.lost_reg && edge_seen
      |=> st_reg.ls1_reg[TXSIL_B_CLKOK] && !st_reg.lost_reg)
      else $error("clock restore not latched");
   // a one written with no set pending clears the bit
   AST_CLR1: assert property (clr1[TXSIL_B_MF] && !set1[TXSIL_B_MF]
      |=> !st_reg.ls1_reg[TXSIL_B_MF])
      else $error("status one bit not cleared");
   // loss bit clears while the live condition stays up
   AST_LOSTCLR: assert property (clr1[TXSIL_B_CLKLOST] && st_reg.lost_reg && !edge_seen
      |=> !st_reg.ls1_reg[TXSIL_B_CLKLOST] && st_reg.lost_reg)
      else $error("loss bit not clearable");

   // ------------------------------------------------------------
   // status two sources
   // ------------------------------------------------------------
   // manual link shifter empty latches in T1 only
   AST_LINK: assert property (!st_reg.ctrl_reg[TXSIL_B_E1] && evt.link_shifter_empty
      |=> st_reg.ls2_reg[TXSIL_B_LINK])
      else $error("link shifter empty not latched");
   // link bit stays low in E1
   AST_LINK_E1: assert property (st_reg.ctrl_reg[TXSIL_B_E1] && !st_reg.ls2_reg[TXSIL_B_LINK]
      |=> !st_reg.ls2_reg[TXSIL_B_LINK])
      else $error("link bit set in E1");
   // fifo underrun latches
   AST_UDR: assert property (evt.fifo_underrun_event |=> st_reg.ls2_reg[TXSIL_B_UDR])
      else $error("underrun not latched");
   // message end latches
   AST_MEND: assert property (evt.message_end_event |=> st_reg.ls2_reg[TXSIL_B_MEND])
      else $error("message end not latched");
   // watermark rising edge latches
   AST_LWM: assert property (cond.below_watermark_cond && !st_reg.lwm_prev_reg
      |=> st_reg.ls2_reg[TXSIL_B_LWM])
      else $error("watermark edge missed");

   // ------------------------------------------------------------
   // status three, summary, masks and pin
   // ------------------------------------------------------------
   // entry into sync search latches
   AST_SDET: assert property (cond.sync_searching && !st_reg.search_prev_reg
      |=> st_reg.ls3_reg)
      else $error("search entry not latched");
   // live search level appears in the read data
   AST_SEARCH_RD: assert property (reg_rd && reg_addr == TXSIL_OFF_LS3 && cond.sync_searching
      |=> reg_rdata[TXSIL_B_SEARCH])
      else $error("search level not read");
   // summary shows status one pending when an enabled bit is set
   AST_SUM_RD: assert property (reg_rd && reg_addr == TXSIL_OFF_SUM
      && (st_reg.ls1_reg & st_reg.im1_reg) != 8'h00 |=> reg_rdata[0])
      else $error("summary misses status one");
   // read data is zero outside the answer cycle
   AST_RDZERO: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   // mask one takes the written byte
   AST_IM1_W: assert property (reg_wr && reg_addr == TXSIL_OFF_IM1
      |=> st_reg.im1_reg == $past(reg_wdata))
      else $error("mask one write lost");
   // mask two keeps only the implemented bits
   AST_IM2_W: assert property (reg_wr && reg_addr == TXSIL_OFF_IM2
      |=> st_reg.im2_reg == ($past(reg_wdata) & TXSIL_LS2_MASK))
      else $error("mask two write lost");
   // mask three keeps bit 0
   AST_IM3_W: assert property (reg_wr && reg_addr == TXSIL_OFF_IM3
      |=> st_reg.im3_reg == $past(reg_wdata[TXSIL_B_SDET]))
      else $error("mask three write lost");
   // all masks closed keeps the pin released
   AST_MASKED: assert property (st_reg.im1_reg == 8'h00 && st_reg.im2_reg == 8'h00
      && !st_reg.im3_reg |=> irq_n)
      else $error("irq with all masks closed");
   // pin releases once no enabled bit remains
   AST_IRQ_REL: assert property ((st_reg.ls1_reg & st_reg.im1_reg) == 8'h00
      && (st_reg.ls2_reg & st_reg.im2_reg) == 8'h00 && !(st_reg.ls3_reg && st_reg.im3_reg)
      |=> irq_n) else $error("irq not released");

   COV_LOST: cover property (st_reg.lost_reg ##[1:100] !st_reg.lost_reg);
   COV_IRQ:  cover property ($fell(irq_n) ##[1:50] $rose(irq_n));
   COV_SEARCH: cover property ($rose(st_reg.ls3_reg));
   // E1 align tick and an underrun reaching the pin
   COV_E1AF: cover property (st_reg.ctrl_reg[TXSIL_B_E1] && evt.align_frame_event);
   COV_UDR:  cover property (evt.fifo_underrun_event ##2 !irq_n);

endmodule
`default_nettype wire

// ===== dv/txsil_host.sv
// host model: register port master that services tx status and masks
`timescale 1ns/1ps
`default_nettype none
module txsil_host (
   input  wire logic        ref_clk,
   input  wire logic [7:0]  reg_rdata,
   output var  logic [11:0] reg_addr,
   output var  logic [7:0]  reg_wdata,
   output var  logic        reg_wr,
   output var  logic        reg_rd
);
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   initial begin
      reg_addr  = 12'h000;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // one strobe cycle; status is cleared by ones only, zeros keep bits
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a; // released lines do not hold the last value
      reg_wdata <= ~d;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge ref_clk);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== dv/txsil_top_tb_top.sv
// testbench: tx status logic against a behavioural status and mask model
`timescale 1ns/1ps
`default_nettype none
module txsil_top_tb_top;
   import txsil_pkg::*;
   logic        ref_clk, arst_n, tx_line_clock, tx_clock_lost, irq_n, reg_wr, reg_rd, run, e1;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, d;
   logic [31:0] seed;
   txsil_evt_t  evt;
   txsil_cond_t cond;
   int          num_errors, num_checks, s1, s2, s3, m1, m2, m3;
   logic [11:0] offs [8] = '{TXSIL_OFF_LS1, TXSIL_OFF_LS2, TXSIL_OFF_LS3, TXSIL_OFF_SUM,
                             TXSIL_OFF_IM1, TXSIL_OFF_IM2, TXSIL_OFF_IM3, 12'h1FF};

   txsil_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .evt(evt), .cond(cond), .tx_line_clock(tx_line_clock),
      .tx_clock_lost(tx_clock_lost), .irq_n(irq_n));
   txsil_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   // status, summary and pin against the model
   task automatic chkall();
      logic [7:0] sm;
      sm = {5'h00, (s3 & m3) != 0, (s2 & m2) != 0, (s1 & m1) != 0};
      host.rd(TXSIL_OFF_LS1, d);
      chk("ls1", d, s1[7:0]);
      host.rd(TXSIL_OFF_LS2, d);
      chk("ls2", d, s2[7:0]);
      host.rd(TXSIL_OFF_LS3, d);
      chk("ls3", d, s3[7:0] | {6'h00, cond.sync_searching, 1'b0});
      host.rd(TXSIL_OFF_SUM, d);
      chk("sum", d, sm);
      chk("irq_n", {7'h00, irq_n}, {7'h00, sm == 8'h00});
   endtask

   task automatic clr_all();
      host.wr(TXSIL_OFF_LS1, 8'hFF);
      host.wr(TXSIL_OFF_LS2, 8'hFF);
      host.wr(TXSIL_OFF_LS3, 8'hFF);
      s1 = 0;
      s2 = 0;
      s3 = 0;
      chkall();
   endtask

   task automatic pulse(input int i);
      @(posedge ref_clk);
      evt <= txsil_evt_t'(10'h001 << i);
      @(posedge ref_clk);
      evt <= txsil_evt_t'(10'h000);
      case (i)
         9: s1 |= 'hA0; // slip also flags on full
         8: s1 |= 'h60;
         7: s1 |= 'h20;
         6: s1 |= e1 ? 0 : 'h10;
         5: s1 |= e1 ? 0 : 'h08;
         4: s1 |= e1 ? 'h08 : 0;
         3: s1 |= 'h04;
         2: s2 |= e1 ? 0 : 'h10;
         1: s2 |= 'h08;
         default: s2 |= 'h04;
      endcase
      chkall();
      clr_all();
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // clocks and watchdog
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      tx_line_clock = 1'b0;
      forever begin
         repeat (TXSIL_LINE_DIV / 2) @(posedge ref_clk);
         if (run) tx_line_clock <= ~tx_line_clock;
      end
   end
   initial begin
      #400000;
      num_errors++;
      summarize();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      {arst_n, e1, s1, s2, s3, m1, m2, m3, num_errors, num_checks} = '0;
      run  = 1'b1;
      evt  = txsil_evt_t'(10'h000);
      cond = txsil_cond_t'(3'h0);
      seed = 32'hD297;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      foreach (offs[k]) begin
         host.rd(offs[k], d);
         chk("reset", d, 8'h00);
      end
      host.wr(TXSIL_OFF_SUM, 8'hFF);
      chkall();
      $display("test reset done");
      for (int p = 0; p < 2; p++) begin
         seed = xs(seed);
         m1 = p ? 'hFF : int'(seed[7:0]);
         m2 = p ? 'h1F : int'(seed[12:8]);
         m3 = p ? 1 : int'(seed[16]);
         host.wr(TXSIL_OFF_IM1, m1[7:0]);
         host.wr(TXSIL_OFF_IM2, m2[7:0]);
         host.wr(TXSIL_OFF_IM3, m3[7:0]);
         host.rd(TXSIL_OFF_IM1, d);
         chk("im1", d, m1[7:0]);
         host.rd(TXSIL_OFF_IM2, d);
         chk("im2", d, m2[7:0]);
         host.rd(TXSIL_OFF_IM3, d);
         chk("im3", d, m3[7:0]);
         e1 = 1'b0;
         host.wr(TXSIL_OFF_CTRL, 8'h02);
         for (int i = 0; i < 10; i++) pulse(i);
         e1 = 1'b1;
         host.wr(TXSIL_OFF_CTRL, 8'h01);
         pulse(4);
         pulse(5);
         pulse(6);
         pulse(2);
         // fifo edges latch once while the level stays high
         @(posedge ref_clk);
         cond <= txsil_cond_t'(3'h6);
         s2 = 3;
         chkall();
         clr_all();
         // searching level is live, detect is latched
         @(posedge ref_clk);
         cond <= txsil_cond_t'(3'h7);
         s3 = 1;
         chkall();
         clr_all();
         @(posedge ref_clk);
         cond <= txsil_cond_t'(3'h0);
         chkall();
         // stop the line clock, clear while lost, then restart it
         run = 1'b0;
         repeat (TXSIL_LOST_EDGES * TXSIL_LINE_DIV + 8) @(posedge ref_clk);
         chk("lost", {7'h00, tx_clock_lost}, 8'h01);
         s1 = 1;
         chkall();
         clr_all();
         chk("lost", {7'h00, tx_clock_lost}, 8'h01);
         run = 1'b1;
         repeat (TXSIL_LINE_DIV * 2) @(posedge ref_clk);
         chk("lost", {7'h00, tx_clock_lost}, 8'h00);
         s1 = 2;
         chkall();
         clr_all();
         $display("test pass %0d done", p);
      end
      summarize();
   end
endmodule
`default_nettype wire
